//--- include/lnkslot_pkg.sv
// Package for the link status / slot capability register logic.
// Assumes a single port clock domain and a simple register access port.
package lnkslot_pkg;

  // Register offsets
  localparam logic [11:0] LINK_STATUS_CONTROL_OFS = 12'h078;
  localparam logic [11:0] SLOT_CAPABILITY_OFS     = 12'h07C;

  // Link status bit positions
  localparam int TRAINING_BIT      = 27;
  localparam int SLOT_CLOCK_BIT    = 28;
  localparam int LINK_ACTIVE_BIT   = 29;
  localparam int BW_MGMT_BIT       = 30;
  localparam int BW_AUTO_BIT       = 31;
  localparam int RETRAIN_BIT       = 5;

  // Slot capability field positions
  localparam int ATTN_BUTTON_BIT   = 0;
  localparam int PWR_CTRL_BIT      = 1;
  localparam int LATCH_SENSOR_BIT  = 2;
  localparam int ATTN_IND_BIT      = 3;
  localparam int PWR_IND_BIT       = 4;
  localparam int SURPRISE_BIT      = 5;
  localparam int HP_CAPABLE_BIT    = 6;
  localparam int PWR_VALUE_LSB     = 7;
  localparam int PWR_SCALE_LSB     = 15;
  localparam int INTERLOCK_BIT     = 17;

  // Reset values
  localparam logic [7:0] PWR_VALUE_RST = 8'h19;
  localparam logic [1:0] PWR_SCALE_RST = 2'h0;
  localparam logic       SURPRISE_RST  = 1'b0;

  // Hot-plug mode of the port
  typedef enum logic [1:0] {
    HP_NONE,
    HP_PARALLEL,
    HP_SERIAL
  } hp_mode_type;

  // Link-layer events from the port core
  typedef struct packed {
    logic training_req;    // Port asked for link training
    logic training_done;   // Training finished
    logic dl_active;       // Data link active, FC init done
    logic link_down;       // Passed through link down
    logic retrain_done;    // Retraining finished
    logic reliab_change;   // Speed/width change for reliability
    logic autonomous_chg;  // Autonomous speed/width change
  } link_event_type;

  // Slot-power message request
  typedef struct packed {
    logic       send;
    logic [7:0] value;
    logic [1:0] scale;
  } power_msg_type;

endpackage

//--- rtl/slot_power_ctrl.sv
// Slot power enable and indicator gating for one downstream slot.
// Assumes synchronous inputs on the port core clock.
`timescale 1ns/1ps
module slot_power_ctrl (
  input  wire logic clock,           // Port core clock
  input  wire logic sys_rst,         // Synchronous reset, high
  input  wire logic pwr_ctrl_present, // Capability bit 1
  input  wire logic latch_present,   // Capability bit 2
  input  wire logic attn_present,    // Capability bit 3
  input  wire logic pwr_ind_present, // Capability bit 4
  input  wire logic retention_latch, // Low when latch closed
  input  wire logic pwr_ctrl_off,    // Power controller control bit
  input  wire logic attn_on,         // Attention indicator request
  input  wire logic pwr_ind_on,      // Power indicator request
  output logic      slot_power_en,   // Slot power enable
  output logic      hp_ctrl_enable,  // Hot-plug controller enabled
  output logic      attention_led_n, // Attention LED, low on
  output logic      power_led_n      // Power LED, low on
);
  import lnkslot_pkg::*;

  logic slot_power_ff;
  logic attn_led_n_ff;
  logic pwr_led_n_ff;
  wire  latch_ok;
  wire  nxt_slot_power;

  // Latch only matters when the sensor exists
  assign latch_ok       = !latch_present || !retention_latch;
  // No power controller: controller off and slot stays down
  assign hp_ctrl_enable = pwr_ctrl_present;
  assign nxt_slot_power = pwr_ctrl_present && latch_ok && !pwr_ctrl_off;

  // Power and LED outputs registered; unused LEDs idle high (off)
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_power_ff <= 1'b0;
      attn_led_n_ff <= 1'b1;
      pwr_led_n_ff  <= 1'b1;
    end else begin
      slot_power_ff <= nxt_slot_power;
      attn_led_n_ff <= !(attn_present && attn_on);
      pwr_led_n_ff  <= !(pwr_ind_present && pwr_ind_on);
    end
  end

  assign slot_power_en   = slot_power_ff;
  assign attention_led_n = attn_led_n_ff;
  assign power_led_n     = pwr_led_n_ff;

  a_no_ctrl_no_power: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(pwr_ctrl_present) |-> !slot_power_en)
    else $error("slot powered without power controller");
  a_latch_open_off: assert property (@(posedge clock) disable iff (sys_rst)
    ($past(latch_present) && $past(retention_latch)) |-> !slot_power_en)
    else $error("slot powered with latch open");
  a_attn_gated: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(attn_present) |-> attention_led_n)
    else $error("attention LED driven when absent");
  a_pwr_led_gated: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(pwr_ind_present) |-> power_led_n)
    else $error("power LED driven when absent");

endmodule // slot_power_ctrl

//--- rtl/link_slot_regs.sv
// Link status upper bits and slot capability register for one port.
// Assumes register access, strap and link event inputs on the port clock.
//
// Operation
// - Training flag high from request until done
// - Bit 28 reflects platform reference clock use
// - Bit 29 shows data link active state
// - Bit 30 set when requested retrain completes
// - Bit 30 set on reliability speed/width change
// - Bit 31 set on autonomous bandwidth change
// - Receiver may always enter L0s
// - Slot capability reads zero on upstream
// - Hot-plug bits default one only when capable
// - Serial capable only after expander detected
// - Owner field picks parallel port; others serial
// - No power controller disables slot power
// - Power up when latch closed, control clear
// - Latch sensor bit enables latch sensing
// - Attention indicator bit gates attention LED
// - Power indicator bit gates power LED
// - Button, surprise and capable bits reported
// - Power limit value defaults to 19h
// - Power scale codes, default 00b
// - Power field write or link up sends message
// - Interlock bit only on serial expander ports
`timescale 1ns/1ps
module link_slot_regs #(
  parameter logic [1:0] PORT_NUM = 2'h1  // Port index within station
) (
  input  wire logic                        clock,            // Port core clock
  input  wire logic                        sys_rst,          // Synchronous reset
  input  wire logic                        is_downstream,    // Port is downstream
  input  wire logic                        platform_refclk,  // Uses connector refclk
  input  wire logic                        link_active_cap,  // Capability 74h[20]
  input  wire logic [1:0]                  parallel_hotplug_owner_port, // 1E0h[14:13]
  input  wire logic                        parallel_hp_en,   // Parallel pins present
  input  wire logic                        expander_found,   // I/O expander detected
  input  wire lnkslot_pkg::link_event_type link_evt,         // Link events
  input  wire logic                        reg_wr,           // Register write strobe
  input  wire logic                        reg_rd,           // Register read strobe
  input  wire logic [11:0]                 reg_addr,         // Register offset
  input  wire logic [31:0]                 reg_wdata,        // Write data
  input  wire logic                        eeprom_wr,        // EEPROM/I2C write
  input  wire logic                        retention_latch,  // Low when closed
  input  wire logic                        pwr_ctrl_off,     // Slot control 80h[10]
  input  wire logic                        attn_on,          // Attention request
  input  wire logic                        pwr_ind_on,       // Power LED request
  output logic [31:0]                      reg_rdata,        // Read data
  output logic                             retrain_req,      // Retrain pulse to core
  output logic                             l0s_rx_allowed,   // Receiver may enter L0s
  output lnkslot_pkg::power_msg_type       power_msg,        // Set_Slot_Power_Limit
  output logic                             slot_power_en,    // Slot power enable
  output logic                             hp_ctrl_enable,   // Hot-plug ctrl enabled
  output logic                             attention_led_n,  // Attention LED, low on
  output logic                             power_led_n       // Power LED, low on
);
  import lnkslot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Hot-plug mode
  logic         training_ff;
  logic         slot_clock_ff;
  logic         bw_mgmt_ff;
  logic         bw_auto_ff;
  logic         retrain_pend_ff;
  logic         dl_active_ff;
  logic [31:0]  rdata_ff;
  logic [7:0]   pwr_value_ff;
  logic [1:0]   pwr_scale_ff;
  logic         surprise_ff;
  power_msg_type msg_ff;
  logic         init_done_ff;
  logic         link_up_ff;

  wire          is_parallel;
  wire          is_serial;
  wire          hp_capable;
  wire          dn_hp;
  hp_mode_type  hp_mode;

  // Parallel pins belong to one port; the rest need a found expander
  assign is_parallel = is_downstream && parallel_hp_en &&
                       (parallel_hotplug_owner_port == PORT_NUM);
  assign is_serial   = is_downstream && !is_parallel && expander_found;
  assign hp_capable  = is_parallel || is_serial;
  assign dn_hp       = hp_capable;
  assign hp_mode     = is_parallel ? HP_PARALLEL : (is_serial ? HP_SERIAL : HP_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  wire wr_link  = reg_wr && (reg_addr == LINK_STATUS_CONTROL_OFS);
  wire wr_slot  = eeprom_wr && (reg_addr == SLOT_CAPABILITY_OFS);
  wire rd_link  = reg_rd && (reg_addr == LINK_STATUS_CONTROL_OFS);
  wire rd_slot  = reg_rd && (reg_addr == SLOT_CAPABILITY_OFS);
  wire clr_mgmt = wr_link && reg_wdata[BW_MGMT_BIT];
  wire clr_auto = wr_link && reg_wdata[BW_AUTO_BIT];
  wire start_retrain = wr_link && reg_wdata[RETRAIN_BIT] && is_downstream;

  ////////////////////////////////////////////////////////////////////////////
  // Status event decode; link-down changes do not count
  wire set_mgmt_retrain = retrain_pend_ff && link_evt.retrain_done &&
                          !link_evt.link_down;
  wire set_mgmt_reliab  = link_evt.reliab_change && !link_evt.link_down;
  wire set_mgmt = is_downstream && (set_mgmt_retrain || set_mgmt_reliab);
  wire set_auto = is_downstream && link_evt.autonomous_chg && !link_evt.link_down;

  // Set beats a simultaneous clear; writing zero leaves bit alone
  wire nxt_bw_mgmt = set_mgmt || (bw_mgmt_ff && !clr_mgmt);
  wire nxt_bw_auto = set_auto || (bw_auto_ff && !clr_auto);

  // Training flag: raised by request, dropped at completion
  wire nxt_training = is_downstream &&
                      (link_evt.training_req || (training_ff && !link_evt.training_done));

  // Active only with reporting capability on downstream ports
  wire nxt_dl_active = is_downstream && link_active_cap && link_evt.dl_active;

  // Remember an outstanding software retrain until it ends or link drops
  wire nxt_retrain_pend = start_retrain ||
                          (retrain_pend_ff && !link_evt.retrain_done && !link_evt.link_down);

  ////////////////////////////////////////////////////////////////////////////
  // Link status state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      training_ff     <= 1'b0;
      bw_mgmt_ff      <= 1'b0;
      bw_auto_ff      <= 1'b0;
      retrain_pend_ff <= 1'b0;
      dl_active_ff    <= 1'b0;
      link_up_ff      <= 1'b0;
    end else begin
      training_ff     <= nxt_training;
      bw_mgmt_ff      <= nxt_bw_mgmt;
      bw_auto_ff      <= nxt_bw_auto;
      retrain_pend_ff <= nxt_retrain_pend;
      dl_active_ff    <= nxt_dl_active;
      link_up_ff      <= link_evt.dl_active;
    end
  end

  // Slot clock config is hardware-initialised once after reset release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_clock_ff <= 1'b0;
      init_done_ff  <= 1'b0;
    end else if (!init_done_ff) begin
      slot_clock_ff <= platform_refclk;
      init_done_ff  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power limit fields; only EEPROM/I2C can change them
  wire [7:0] nxt_pwr_value = wr_slot ? reg_wdata[PWR_VALUE_LSB +: 8] : pwr_value_ff;
  wire [1:0] nxt_pwr_scale = wr_slot ? reg_wdata[PWR_SCALE_LSB +: 2] : pwr_scale_ff;
  wire       nxt_surprise  = wr_slot ? reg_wdata[SURPRISE_BIT] : surprise_ff;

  // Message on a field write or on rising data-link-active; raw link state is
  // used so the reporting capability neither hides nor fakes a link-up
  wire link_up_evt = link_evt.dl_active && !link_up_ff;
  wire send_msg    = is_downstream && (wr_slot || link_up_evt);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwr_value_ff <= PWR_VALUE_RST;
      pwr_scale_ff <= PWR_SCALE_RST;
      surprise_ff  <= SURPRISE_RST;
      msg_ff       <= '0;
    end else begin
      pwr_value_ff <= nxt_pwr_value;
      pwr_scale_ff <= nxt_pwr_scale;
      surprise_ff  <= nxt_surprise;
      msg_ff.send  <= send_msg;
      msg_ff.value <= nxt_pwr_value;
      msg_ff.scale <= nxt_pwr_scale;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot capability image; all zero on the upstream port
  logic [31:0] slot_cap;
  always_comb begin
    slot_cap = 32'h0000_0000;
    if (is_downstream) begin
      slot_cap[ATTN_BUTTON_BIT]          = dn_hp;
      slot_cap[PWR_CTRL_BIT]             = dn_hp;
      slot_cap[LATCH_SENSOR_BIT]         = dn_hp;
      slot_cap[ATTN_IND_BIT]             = dn_hp;
      slot_cap[PWR_IND_BIT]              = dn_hp;
      slot_cap[SURPRISE_BIT]             = surprise_ff;
      slot_cap[HP_CAPABLE_BIT]           = dn_hp;
      slot_cap[PWR_VALUE_LSB +: 8]       = pwr_value_ff;
      slot_cap[PWR_SCALE_LSB +: 2]       = pwr_scale_ff;
      slot_cap[INTERLOCK_BIT]            = (hp_mode == HP_SERIAL);
    end
  end

  // Link status upper bits; lower control bits live elsewhere
  wire [31:0] link_word = {bw_auto_ff, bw_mgmt_ff, dl_active_ff, slot_clock_ff,
                           training_ff, 27'h0000000};

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= rd_link ? link_word : (rd_slot ? slot_cap : 32'h0000_0000);
    end
  end

  assign reg_rdata      = rdata_ff;
  assign retrain_req    = start_retrain;
  assign l0s_rx_allowed = 1'b1;
  assign power_msg      = msg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Slot power and indicators
  slot_power_ctrl i_slot_power_ctrl (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .pwr_ctrl_present (slot_cap[PWR_CTRL_BIT]),
    .latch_present    (slot_cap[LATCH_SENSOR_BIT]),
    .attn_present     (slot_cap[ATTN_IND_BIT]),
    .pwr_ind_present  (slot_cap[PWR_IND_BIT]),
    .retention_latch  (retention_latch),
    .pwr_ctrl_off     (pwr_ctrl_off),
    .attn_on          (attn_on),
    .pwr_ind_on       (pwr_ind_on),
    .slot_power_en    (slot_power_en),
    .hp_ctrl_enable   (hp_ctrl_enable),
    .attention_led_n  (attention_led_n),
    .power_led_n      (power_led_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_training_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (training_ff && !link_evt.training_done && is_downstream) |=> training_ff)
    else $error("training flag dropped early");
  a_active_gate: assert property (@(posedge clock) disable iff (sys_rst)
    dl_active_ff |-> $past(link_active_cap && link_evt.dl_active))
    else $error("link active without cause");
  a_mgmt_set_wins: assert property (@(posedge clock) disable iff (sys_rst)
    (set_mgmt && clr_mgmt) |=> bw_mgmt_ff)
    else $error("bandwidth mgmt set lost to clear");
  a_reliab_sets: assert property (@(posedge clock) disable iff (sys_rst)
    (is_downstream && link_evt.reliab_change && !link_evt.link_down) |=> bw_mgmt_ff)
    else $error("reliability change missed");
  a_auto_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    (bw_auto_ff && !clr_auto) |=> bw_auto_ff)
    else $error("autonomous status lost");
  a_upstream_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (!is_downstream && rd_slot) |=> (reg_rdata == 32'h0000_0000))
    else $error("slot capability nonzero upstream");
  a_serial_needs_exp: assert property (@(posedge clock) disable iff (sys_rst)
    slot_cap[INTERLOCK_BIT] |-> (expander_found && !is_parallel))
    else $error("serial mode without expander");
  a_msg_on_linkup: assert property (@(posedge clock) disable iff (sys_rst)
    (is_downstream && link_up_evt) |=> power_msg.send)
    else $error("no power message at link up");
  a_interlock_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (is_parallel || !is_downstream) |-> !slot_cap[INTERLOCK_BIT])
    else $error("interlock bit on non-serial port");

endmodule // link_slot_regs

//--- bench/slot_dev_model.sv
// Behavioural model of the device in the downstream slot and its chassis.
// Assumes the bench sets link_on and latch_closed just after a clock edge.
`timescale 1ns/1ps
module slot_dev_model (
  input  wire logic                       clock,           // Port core clock
  input  wire logic                       sys_rst,         // Synchronous reset
  input  wire lnkslot_pkg::power_msg_type power_msg,       // Message from port
  input  wire logic                       link_on,         // Bench wants link up
  input  wire logic                       latch_closed,    // Bench closes latch
  output logic                            dl_active,       // Link active level
  output logic                            retention_latch, // Low when closed
  output logic [7:0]                      cap_value,       // Captured limit value
  output logic [1:0]                      cap_scale,       // Captured limit scale
  output logic [7:0]                      msg_cnt          // Messages received
);
  import lnkslot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link state and latch pin follow the bench directly
  assign dl_active       = link_on;
  assign retention_latch = ~latch_closed; // Closed latch pulls the pin low

  // Capture the limit like the upstream port of the slot device would
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cap_value <= 8'h00;
      cap_scale <= 2'h0;
      msg_cnt   <= 8'h00;
    end else if (power_msg.send) begin
      cap_value <= power_msg.value;
      cap_scale <= power_msg.scale;
      msg_cnt   <= msg_cnt + 8'h01;
    end
  end
endmodule // slot_dev_model

//--- bench/link_slot_regs_bench.sv
// Self-checking bench for the link status and slot capability logic.
// Assumes the design and package are compiled first; drives 1 ns after edges.
`timescale 1ns/1ps
module link_slot_regs_bench;
  import lnkslot_pkg::*;
  logic clock, sys_rst, is_downstream, platform_refclk, link_active_cap, parallel_hp_en;
  logic expander_found, reg_wr, reg_rd, eeprom_wr, pwr_ctrl_off, attn_on, pwr_ind_on;
  logic link_on, latch_closed, dl_active, retention_latch, retrain_req, l0s_rx_allowed;
  logic slot_power_en, hp_ctrl_enable, attention_led_n, power_led_n, rq;
  logic [1:0]     parallel_hotplug_owner_port, cap_scale;
  logic [11:0]    reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, rd_val, exp_w;
  logic [7:0]     cap_value, msg_cnt;
  link_event_type link_evt, pulse_v;
  power_msg_type  power_msg;
  int             err_total, cmp_count;
  localparam logic [31:0] CAP_EXP [4] = '{32'hCDF, 32'h20CDF, 32'hC80, 32'h0};
  localparam logic [3:0]  CAPABLE = 4'b0011; // Index 0 is the lowest bit

  ////////////////////////////////////////////////////////////////////////////
  // Design, slot device and event merge
  always_comb begin
    link_evt           = pulse_v;
    link_evt.dl_active = dl_active;
  end
  link_slot_regs #(.PORT_NUM(2'h1)) i_link_slot_regs (.clock(clock), .sys_rst(sys_rst),
    .is_downstream(is_downstream), .platform_refclk(platform_refclk),
    .link_active_cap(link_active_cap), .parallel_hotplug_owner_port(parallel_hotplug_owner_port),
    .parallel_hp_en(parallel_hp_en), .expander_found(expander_found), .link_evt(link_evt),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .eeprom_wr(eeprom_wr), .retention_latch(retention_latch), .pwr_ctrl_off(pwr_ctrl_off),
    .attn_on(attn_on), .pwr_ind_on(pwr_ind_on), .reg_rdata(reg_rdata),
    .retrain_req(retrain_req), .l0s_rx_allowed(l0s_rx_allowed), .power_msg(power_msg),
    .slot_power_en(slot_power_en), .hp_ctrl_enable(hp_ctrl_enable),
    .attention_led_n(attention_led_n), .power_led_n(power_led_n));
  slot_dev_model i_slot_dev_model (.clock(clock), .sys_rst(sys_rst), .power_msg(power_msg),
    .link_on(link_on), .latch_closed(latch_closed), .dl_active(dl_active),
    .retention_latch(retention_latch), .cap_value(cap_value), .cap_scale(cap_scale),
    .msg_cnt(msg_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, access tasks and comparison
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    tick(1);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    #1 rq = retrain_req; // Retrain pulse shows while the write strobe is up
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    tick(1);
    reg_rd   = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  task automatic lnk(input logic [31:0] exp);
    rd(12'h078);
    chk(rd_val & 32'hF800_0000, exp); // Lower control bits live elsewhere
  endtask
  task automatic pulse(input logic [6:0] p);
    tick(1);
    pulse_v = link_event_type'(p);
    tick(1);
    pulse_v = '0;
  endtask
  // Shadow write of the capability word; send is checked one cycle later
  task automatic eeprom(input logic [31:0] d, input logic exp_send);
    tick(1);
    eeprom_wr = 1'b1;
    reg_addr  = 12'h07C;
    reg_wdata = d;
    tick(1);
    eeprom_wr = 1'b0;
    chk(32'(power_msg.send), 32'(exp_send));
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
  endtask
  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 110 cycles the sequence needs
  initial begin
    #40000;
    err_total++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {sys_rst, is_downstream, platform_refclk, link_active_cap, parallel_hp_en} = 5'b11111;
    {expander_found, reg_wr, reg_rd, eeprom_wr, pwr_ctrl_off, attn_on, pwr_ind_on} = '0;
    {link_on, latch_closed, rq} = '0;
    parallel_hotplug_owner_port = 2'h1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    pulse_v = '0;
    err_total = 0;
    cmp_count = 0;
    // Strap combinations: parallel owner, serial, no expander, upstream
    for (int i = 0; i < 4; i++) begin
      is_downstream = (i != 3);
      parallel_hotplug_owner_port = (i == 1 || i == 2) ? 2'h2 : 2'h1;
      expander_found = (i == 1 || i == 3);
      platform_refclk = i[0];
      {latch_closed, pwr_ctrl_off, attn_on, pwr_ind_on} = 4'b1011;
      do_reset();
      rd(12'h07C);
      chk(rd_val, CAP_EXP[i]);
      lnk(32'(i[0]) << 28);
      chk(32'(hp_ctrl_enable), 32'(CAPABLE[i]));
      chk(32'(slot_power_en), 32'(CAPABLE[i]));
      chk(32'(attention_led_n), 32'(!CAPABLE[i]));
      chk(32'(power_led_n), 32'(!CAPABLE[i]));
      if (i == 3) eeprom(32'h0, 1'b0);
    end
    // Parallel owner port with the platform clock for the rest
    {is_downstream, parallel_hotplug_owner_port, expander_found, platform_refclk} = 5'b10101;
    do_reset();
    chk(32'(l0s_rx_allowed), 32'h1);
    pulse(7'h40);
    lnk(32'h1800_0000);
    pulse(7'h20);
    lnk(32'h1000_0000);
    link_on = 1'b1;
    tick(1);
    chk(32'(power_msg.send), 32'h1);
    tick(1);
    chk(32'({cap_value, cap_scale}), 32'h64);
    lnk(32'h3000_0000);
    link_active_cap = 1'b0;
    lnk(32'h1000_0000);
    link_active_cap = 1'b1;
    // Requested retrain, write-one-to-clear, zero writes ignored
    wr(12'h078, 32'h20);
    chk(32'(rq), 32'h1);
    pulse(7'h04);
    lnk(32'h7000_0000);
    wr(12'h078, 32'h0);
    lnk(32'h7000_0000);
    wr(12'h078, 32'h4000_0000);
    lnk(32'h3000_0000);
    // Link down between request and completion cancels the status
    wr(12'h078, 32'h20);
    pulse(7'h08);
    pulse(7'h04);
    lnk(32'h3000_0000);
    pulse(7'h02);
    lnk(32'h7000_0000);
    wr(12'h078, 32'h4000_0000);
    pulse(7'h01);
    lnk(32'hB000_0000);
    // Clear and hardware set in one cycle: the set must survive
    tick(1);
    reg_wr = 1'b1;
    reg_addr = 12'h078;
    reg_wdata = 32'hC000_0000;
    pulse_v = link_event_type'(7'h03);
    tick(1);
    reg_wr = 1'b0;
    pulse_v = '0;
    lnk(32'hF000_0000);
    wr(12'h078, 32'hC000_0000);
    lnk(32'h3000_0000);
    // Every scale code through the shadow write path
    for (int s = 0; s < 4; s++) begin
      exp_w = 32'h5F | (32'(s & 1) << 5) | ((32'h20 + 32'(s)) << 7) | (32'(s) << 15);
      eeprom(exp_w, 1'b1);
      chk(32'({power_msg.value, power_msg.scale}), 32'(((32'h20 + s) << 2) | s));
      rd(12'h07C);
      chk(rd_val, exp_w);
    end
    chk(32'(msg_cnt), 32'h5);
    wr(12'h07C, 32'h0);
    rd(12'h07C);
    chk(rd_val, exp_w);
    rd(12'h100);
    chk(rd_val, 32'h0);
    // Latch, power control and indicators
    {latch_closed, pwr_ctrl_off, attn_on, pwr_ind_on} = 4'b0010;
    tick(2);
    chk(32'({slot_power_en, attention_led_n, power_led_n}), 32'h1);
    {latch_closed, pwr_ctrl_off} = 2'b11;
    tick(2);
    chk(32'(slot_power_en), 32'h0);
    pwr_ctrl_off = 1'b0;
    tick(2);
    chk(32'(slot_power_en), 32'h1);
    test_done();
  end
endmodule // link_slot_regs_bench
